// file: bench/pdsc_assertions.sv
// Port checker for the strap and control block
`timescale 1ns/1ps
`default_nettype none
module pdsc_assertions (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic       chip_reset_n,
   input wire logic       standby_n_pin,
   input wire logic       host_port_select,
   input wire logic       chip_in_reset,
   input wire logic       display_active,
   input wire logic       standby_active,
   input wire logic       host_port_is_i2c,
   input wire logic [1:0] timing_mode,
   input wire logic       timing_mode_reserved,
   input wire logic       horizontal_scan_dir_eff,
   input wire logic       vertical_scan_dir_eff,
   input wire logic [8:0] source_first_channel,
   input wire logic [8:0] source_last_channel,
   input wire logic [9:0] gate_first_line,
   input wire logic [9:0] gate_last_line,
   input wire logic       reload_request,
   input wire logic       self_protect_active
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus slave not ready or not okay");
   chan_order_a: assert property ($stable(horizontal_scan_dir_eff)[*2] |->
      source_first_channel == (horizontal_scan_dir_eff ? 9'h001 : 9'h1E0) &&
      source_last_channel == (horizontal_scan_dir_eff ? 9'h1E0 : 9'h001))
      else $error("source channel order wrong");
   gate_order_a: assert property ($stable(vertical_scan_dir_eff)[*2] |->
      gate_first_line == (vertical_scan_dir_eff ? 10'h001 : 10'h348) &&
      gate_last_line == (vertical_scan_dir_eff ? 10'h348 : 10'h001))
      else $error("gate line order wrong");
   mode_resv_a: assert property (timing_mode_reserved == timing_mode[1])
      else $error("reserved mode flag wrong");
   pulse_once_a: assert property (reload_request |=> !reload_request)
      else $error("reload pulse too long");
   reset_hold_a: assert property ((!chip_reset_n)[*4] |=>
      chip_in_reset && !display_active)
      else $error("chip reset not held");
   standby_hold_a: assert property ((!standby_n_pin && chip_reset_n)[*5] |=>
      standby_active && !display_active)
      else $error("standby pin ignored");
   port_sel_a: assert property ($stable(host_port_select)[*3] |=>
      host_port_is_i2c == $past(host_port_select))
      else $error("host port choice wrong");
   // ----------------------------------------
   // Covers
   // ----------------------------------------
   reload_c: cover property (reload_request);
   protect_c: cover property (self_protect_active);
   standby_c: cover property (standby_active);
endmodule // pdsc_assertions
bind pdsc_top pdsc_assertions u_pdsc_assertions (.*);
`default_nettype wire

// file: bench/pdsc_top_tb.sv
// Testbench for the strap and control block
`timescale 1ns/1ps
`default_nettype none
module pdsc_top_tb;
   logic        hclk, hresetn, hsel, hwrite, chip_reset_n, pin_or_register_select;
   logic        auto_reload_enable, ext_eeprom_enable, host_port_select, standby_n_pin;
   logic        video_input_type_select, horizontal_scan_dir, vertical_scan_dir;
   logic        interlace_pin, self_test_pin, hreadyout, hresp, h, v;
   logic        pixel_clock, line_sync, frame_sync, pixel_valid;
   logic        chip_in_reset, standby_active, display_active, host_port_is_i2c;
   logic        lvds_selected, timing_mode_reserved, horizontal_scan_dir_eff;
   logic        vertical_scan_dir_eff, interlace_active, self_test_active;
   logic        self_protect_active, internal_video_source, reload_request, reload_from_eeprom;
   logic [1:0]  htrans, timing_mode_pin, timing_mode;
   logic [2:0]  hsize;
   logic [3:0]  drop;
   logic [8:0]  source_first_channel, source_last_channel;
   logic [9:0]  gate_first_line, gate_last_line;
   logic [31:0] haddr, hwdata, hrdata, rd;
   wire         hready;
   int          failures, checks_done, n;
   assign hready = hreadyout;
   pdsc_top #(.INT_FRAME_CYCLES(50)) u_pdsc_top (.*);
   pdsc_video_host u_pdsc_video_host (.*);
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic settle;
      repeat (8) @(posedge hclk);
   endtask
   task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
      logic rdy;
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {24'h000000, idx, 2'h0};
      do begin
         @(negedge hclk);
         rdy = hready;
         @(posedge hclk);
      end while (rdy !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin
         @(negedge hclk);
         rdy = hready;
         rd = hrdata;
         @(posedge hclk);
      end while (rdy !== 1'b1);
   endtask
   task automatic wait_pulse;
      n = 0;
      do begin
         @(negedge hclk);
         n++;
      end while (reload_request !== 1'b1 && n < 5000);
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ----------------------------------------
   // Clock and watchdog
   // ----------------------------------------
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial begin
      #400us;
      failures++;
      finish_test;
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      failures = 0;
      checks_done = 0;
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, drop} = '0;
      hsize = 3'h2;
      {chip_reset_n, pin_or_register_select, auto_reload_enable, standby_n_pin} = 4'hF;
      {ext_eeprom_enable, host_port_select, video_input_type_select} = 3'h0;
      {interlace_pin, self_test_pin, timing_mode_pin} = 4'h1;
      {horizontal_scan_dir, vertical_scan_dir} = 2'h3;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      settle;
      chk(display_active, 1'b1);
      bus(1'b0, 6'h02, 32'h0);
      chk(rd, 32'h02);
      bus(1'b0, 6'h3F, 32'h0);
      chk(rd, 32'h0);
      for (int i = 0; i < 4; i++) begin
         host_port_select <= i[0];
         timing_mode_pin  <= i[1:0];
         interlace_pin    <= i[1];
         settle;
         chk(interlace_active, i[1]);
         chk(host_port_is_i2c, i[0]);
         chk(timing_mode, i[1:0]);
      end
      timing_mode_pin <= 2'h1;
      bus(1'b1, 6'h03, 32'hC0);
      for (int i = 0; i < 8; i++) begin
         pin_or_register_select <= i[2];
         horizontal_scan_dir    <= i[0];
         vertical_scan_dir      <= i[1];
         settle;
         h = i[0] ^ !i[2];
         v = i[1] ^ !i[2];
         chk({source_first_channel, source_last_channel}, h ? 18'h003E0 : 18'h3C001);
         chk({gate_first_line, gate_last_line}, v ? 20'h00748 : 20'hD2001);
      end
      pin_or_register_select <= 1'b0;
      bus(1'b1, 6'h02, 32'h40);
      settle;
      chk({lvds_selected, timing_mode}, 3'h4);
      bus(1'b1, 6'h01, 32'h55);
      settle;
      chk({standby_active, display_active}, 2'h2);
      bus(1'b1, 6'h01, 32'h54);
      settle;
      chk(standby_active, 1'b0);
      standby_n_pin <= 1'b0;
      settle;
      chk(standby_active, 1'b1);
      standby_n_pin <= 1'b1;
      chip_reset_n  <= 1'b0;
      settle;
      chk({chip_in_reset, display_active}, 2'h2);
      bus(1'b0, 6'h03, 32'h0);
      chk(rd, 32'h0);
      chip_reset_n           <= 1'b1;
      pin_or_register_select <= 1'b1;
      self_test_pin          <= 1'b1;
      settle;
      chk({self_test_active, internal_video_source}, 2'h3);
      self_test_pin <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         video_input_type_select <= i[0];
         drop <= 4'h8;
         n = 0;
         do begin
            @(negedge hclk);
            n++;
         end while (self_protect_active !== 1'b1 && n < 1100);
         @(posedge hclk);
         chk({self_protect_active, lvds_selected}, {!i[0], i[0]});
         drop <= 4'h0;
         settle;
         chk(self_protect_active, 1'b0);
      end
      video_input_type_select <= 1'b0;
      ext_eeprom_enable <= 1'b1;
      wait_pulse;
      wait_pulse;
      chk(n, 60 * 64);
      chk(reload_from_eeprom, 1'b1);
      @(posedge hclk);
      ext_eeprom_enable <= 1'b0;
      wait_pulse;
      chk(reload_from_eeprom, 1'b0);
      @(posedge hclk);
      auto_reload_enable <= 1'b0;
      wait_pulse;
      chk(n, 5000);
      finish_test;
   end
endmodule // pdsc_top_tb
`default_nettype wire

// file: bench/pdsc_video_host.sv
// Host display controller model driving the video timing pins
`timescale 1ns/1ps
`default_nettype none
module pdsc_video_host #(
   parameter int FRAME = 64
) (
   input  wire logic       hclk,
   input  wire logic [3:0] drop,
   output var  logic       pixel_clock,
   output var  logic       line_sync,
   output var  logic       frame_sync,
   output var  logic       pixel_valid
);
   // ----------------------------------------
   // Timing generator, a set drop bit holds that pin still
   // ----------------------------------------
   int unsigned cnt = 0;
   initial {pixel_clock, line_sync, frame_sync, pixel_valid} = 4'h0;
   always @(posedge hclk) begin
      cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
      if (!drop[3]) pixel_clock <= !pixel_clock;
      if (!drop[2]) line_sync <= (cnt[3:0] == 4'h0);
      if (!drop[1]) frame_sync <= (cnt < 4);
      if (!drop[0]) pixel_valid <= (cnt[3:0] >= 4'h4);
   end
endmodule // pdsc_video_host
`default_nettype wire

// file: rtl/pdsc_defs.vh
// Constants for the panel driver strap and control block
`ifndef PDSC_DEFS_VH
`define PDSC_DEFS_VH
// ----------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------
`define PDSC_IDX_STANDBY   6'h01
`define PDSC_IDX_INPUT     6'h02
`define PDSC_IDX_SCAN      6'h03
`define PDSC_IDX_TEST      6'h05
`define PDSC_IDX_STATUS    6'h08
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PDSC_BIT_VIDEO     6
`define PDSC_BIT_MODE_HI   2
`define PDSC_BIT_MODE_LO   1
`define PDSC_BIT_HDIR      7
`define PDSC_BIT_VDIR      6
`define PDSC_BIT_INTERLACE 3
`define PDSC_BIT_BIST      4
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PDSC_RST_STANDBY   8'h00
`define PDSC_RST_INPUT     8'h02
`define PDSC_RST_SCAN      8'h00
`define PDSC_RST_TEST      8'h00
`define PDSC_PIN_DEFAULTS  13'h0C9C
// ----------------------------------------
// Codes and counts
// ----------------------------------------
`define PDSC_STANDBY_KEY   8'h55
`define PDSC_MODE_DE       2'h0
`define PDSC_MODE_SYNC     2'h1
`define PDSC_RELOAD_FRAMES 6'h3C
`define PDSC_SRC_CHANNELS  9'h1E0
`define PDSC_GATE_LINES    10'h348
`define PDSC_FIRST_INDEX   1
// ----------------------------------------
// Timing
// ----------------------------------------
`define PDSC_CLK_NS        10
`define PDSC_MISSING_NS    10000
`define PDSC_MISSING_CYC   (`PDSC_MISSING_NS / `PDSC_CLK_NS)
`define PDSC_FRAME_NS      16666667
`define PDSC_FRAME_CYC     (`PDSC_FRAME_NS / `PDSC_CLK_NS)
`endif

// file: rtl/pdsc_top.v
// Strap resolution, standby, reload pacing and self protection with AHB-Lite registers
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pdsc_defs.vh"

// Notes on behaviour
// - Reset pin low holds chip in reset
// - Select high uses pins, low registers
// - Register mode: scan direction is pin XOR bit
// - Auto reload every 60 frames when enabled
// - Reload source EEPROM if enabled, else OTP
// - EEPROM enable high enables, default disabled
// - Host port select: 1 I2C, 0 SPI
// - Standby pin low forces standby
// - Video type: 0 TTL, 1 LVDS
// - Timing mode 00 DE, 01 sync, 1x reserved
// - Horizontal direction sets source channel order
// - Vertical direction sets gate line order
// - Missing video input in TTL mode enters internal-oscillator protection
// - Self test uses internal patterns
// - Pin high: standby only if command is 0x55
// - Register mode: other settings from registers only; host port select, EEPROM enable and auto reload still come from pins
module pdsc_top #(
   parameter INT_FRAME_CYCLES = `PDSC_FRAME_CYC
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   input  wire        chip_reset_n,
   input  wire        pin_or_register_select,
   input  wire        auto_reload_enable,
   input  wire        ext_eeprom_enable,
   input  wire        host_port_select,
   input  wire        standby_n_pin,
   input  wire        video_input_type_select,
   input  wire [1:0]  timing_mode_pin,
   input  wire        horizontal_scan_dir,
   input  wire        vertical_scan_dir,
   input  wire        interlace_pin,
   input  wire        self_test_pin,
   input  wire        pixel_clock,
   input  wire        line_sync,
   input  wire        frame_sync,
   input  wire        pixel_valid,
   output reg         chip_in_reset,
   output reg         standby_active,
   output reg         display_active,
   output reg         host_port_is_i2c,
   output reg         lvds_selected,
   output reg  [1:0]  timing_mode,
   output reg         timing_mode_reserved,
   output reg         horizontal_scan_dir_eff,
   output reg         vertical_scan_dir_eff,
   output reg         interlace_active,
   output reg         self_test_active,
   output reg         self_protect_active,
   output reg         internal_video_source,
   output reg  [8:0]  source_first_channel,
   output reg  [8:0]  source_last_channel,
   output reg  [9:0]  gate_first_line,
   output reg  [9:0]  gate_last_line,
   output reg         reload_request,
   output reg         reload_from_eeprom
);

   localparam [2:0] ST_RESET   = 3'h0;
   localparam [2:0] ST_STANDBY = 3'h1;
   localparam [2:0] ST_NORMAL  = 3'h2;
   localparam [2:0] ST_PROTECT = 3'h3;
   localparam [2:0] ST_SELFTST = 3'h4;
   localparam integer MISS_I    = `PDSC_MISSING_CYC - 1;
   localparam integer LAST_I    = INT_FRAME_CYCLES - 1;
   localparam integer FIRST_I   = `PDSC_FIRST_INDEX;
   localparam [9:0]  MISS_LIMIT  = MISS_I[9:0];
   localparam [20:0] INT_LAST    = LAST_I[20:0];
   localparam [5:0]  RELOAD_LAST = `PDSC_RELOAD_FRAMES - 6'h01;
   localparam [8:0]  SRC_FIRST   = FIRST_I[8:0];
   localparam [9:0]  GATE_FIRST  = FIRST_I[9:0];
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   reg  [12:0] pin_s1;
   reg  [12:0] pin_s2;
   reg  [3:0]  vid_s1;
   reg  [3:0]  vid_s2;
   reg  [3:0]  vid_prev;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1   <= `PDSC_PIN_DEFAULTS;
         pin_s2   <= `PDSC_PIN_DEFAULTS;
         vid_s1   <= 4'h0;
         vid_s2   <= 4'h0;
         vid_prev <= 4'h0;
      end else begin
         pin_s1   <= {chip_reset_n, pin_or_register_select, auto_reload_enable,
                      ext_eeprom_enable, host_port_select, standby_n_pin,
                      video_input_type_select, timing_mode_pin, horizontal_scan_dir,
                      vertical_scan_dir, interlace_pin, self_test_pin};
         pin_s2   <= pin_s1;
         vid_s1   <= {pixel_clock, line_sync, frame_sync, pixel_valid};
         vid_s2   <= vid_s1;
         vid_prev <= vid_s2;
      end
   end

   wire       rst_n_s   = pin_s2[12];
   wire       hw_sel_s  = pin_s2[11];
   wire       auto_s    = pin_s2[10];
   wire       eep_s     = pin_s2[9];
   wire       i2c_s     = pin_s2[8];
   wire       stby_n_s  = pin_s2[7];
   wire       video_s   = pin_s2[6];
   wire [1:0] mode_s    = pin_s2[5:4];
   wire       hdir_s    = pin_s2[3];
   wire       vdir_s    = pin_s2[2];
   wire       intl_s    = pin_s2[1];
   wire       test_s    = pin_s2[0];
   wire [3:0] vid_edge  = vid_s2 ^ vid_prev;

   // ----------------------------------------
   // AHB-Lite slave
   // ----------------------------------------
   reg        d_valid;
   reg        d_write;
   reg  [5:0] d_idx;
   reg  [7:0] standby_command_reg;
   reg  [7:0] input_cfg_reg;
   reg  [7:0] scan_cfg_reg;
   reg  [7:0] test_cfg_reg;
   reg  [31:0] status_word;

   wire a_take   = hsel & htrans[1] & hready;
   wire a_mapped = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'h0) & (hsize == 3'h2);

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         d_valid <= 1'b0;
         d_write <= 1'b0;
         d_idx   <= 6'h00;
      end else if (hready) begin
         d_valid <= a_take & a_mapped;
         d_write <= hwrite;
         d_idx   <= haddr[7:2];
      end
   end

   wire wr_now = d_valid & d_write;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         standby_command_reg <= `PDSC_RST_STANDBY;
         input_cfg_reg       <= `PDSC_RST_INPUT;
         scan_cfg_reg        <= `PDSC_RST_SCAN;
         test_cfg_reg        <= `PDSC_RST_TEST;
      end else if (!rst_n_s) begin
         standby_command_reg <= `PDSC_RST_STANDBY;
         input_cfg_reg       <= `PDSC_RST_INPUT;
         scan_cfg_reg        <= `PDSC_RST_SCAN;
         test_cfg_reg        <= `PDSC_RST_TEST;
      end else if (wr_now) begin
         case (d_idx)
            `PDSC_IDX_STANDBY: standby_command_reg <= hwdata[7:0];
            `PDSC_IDX_INPUT:   input_cfg_reg       <= hwdata[7:0];
            `PDSC_IDX_SCAN:    scan_cfg_reg        <= hwdata[7:0];
            `PDSC_IDX_TEST:    test_cfg_reg        <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   always @* begin
      hrdata = 32'h00000000;
      if (d_valid && !d_write) begin
         case (d_idx)
            `PDSC_IDX_STANDBY: hrdata = {24'h000000, standby_command_reg};
            `PDSC_IDX_INPUT:   hrdata = {24'h000000, input_cfg_reg};
            `PDSC_IDX_SCAN:    hrdata = {24'h000000, scan_cfg_reg};
            `PDSC_IDX_TEST:    hrdata = {24'h000000, test_cfg_reg};
            `PDSC_IDX_STATUS:  hrdata = status_word;
            default:           hrdata = 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------
   // Setting resolution
   // ----------------------------------------
   wire       reg_video = input_cfg_reg[`PDSC_BIT_VIDEO];
   wire [1:0] reg_mode  = input_cfg_reg[`PDSC_BIT_MODE_HI:`PDSC_BIT_MODE_LO];
   wire       reg_hdir  = scan_cfg_reg[`PDSC_BIT_HDIR];
   wire       reg_vdir  = scan_cfg_reg[`PDSC_BIT_VDIR];
   wire       reg_intl  = scan_cfg_reg[`PDSC_BIT_INTERLACE];
   wire       reg_test  = test_cfg_reg[`PDSC_BIT_BIST];

   wire       eff_video = hw_sel_s ? video_s : reg_video;
   wire [1:0] eff_mode  = hw_sel_s ? mode_s  : reg_mode;
   wire       eff_intl  = hw_sel_s ? intl_s  : reg_intl;
   wire       eff_test  = hw_sel_s ? test_s  : reg_test;
   wire       eff_hdir  = hw_sel_s ? hdir_s  : (hdir_s ^ reg_hdir);
   wire       eff_vdir  = hw_sel_s ? vdir_s  : (vdir_s ^ reg_vdir);
   wire       eff_stby  = !stby_n_s | (standby_command_reg == `PDSC_STANDBY_KEY);
   wire       mode_resv = eff_mode[1];
   wire       sync_mode = (eff_mode == `PDSC_MODE_SYNC);

   // ----------------------------------------
   // Operating state
   // ----------------------------------------
   reg  [2:0] op_state;
   reg  [2:0] next_op_state;
   wire [3:0] missing;
   wire       any_missing = |missing;

   always @* begin
      if (!rst_n_s)
         next_op_state = ST_RESET;
      else if (eff_stby)
         next_op_state = ST_STANDBY;
      else if (eff_test)
         next_op_state = ST_SELFTST;
      else if (any_missing)
         next_op_state = ST_PROTECT;
      else
         next_op_state = ST_NORMAL;
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         op_state <= ST_RESET;
      else
         op_state <= next_op_state;
   end

   reg running;
   reg internal_src;

   always @* begin
      case (op_state)
         ST_NORMAL:  begin running = 1'b1; internal_src = 1'b0; end
         ST_PROTECT: begin running = 1'b1; internal_src = 1'b1; end
         ST_SELFTST: begin running = 1'b1; internal_src = 1'b1; end
         default:    begin running = 1'b0; internal_src = 1'b0; end
      endcase
   end

   // ----------------------------------------
   // Missing input watchdogs
   // ----------------------------------------
   wire       ttl_watch = running & (op_state != ST_SELFTST) & !eff_video;
   wire [3:0] watch = {ttl_watch, ttl_watch & sync_mode, ttl_watch & sync_mode, ttl_watch};
   reg  [9:0] miss_cnt [0:3];

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_watch
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn)
               miss_cnt[g] <= 10'h000;
            else if (!watch[g] || vid_edge[g])
               miss_cnt[g] <= 10'h000;
            else if (miss_cnt[g] != MISS_LIMIT)
               miss_cnt[g] <= miss_cnt[g] + 10'h001;
         end
         assign missing[g] = watch[g] & (miss_cnt[g] == MISS_LIMIT);
      end
   endgenerate

   // ----------------------------------------
   // Frame pacing and table reload
   // ----------------------------------------
   reg  [20:0] int_cnt;
   reg  [5:0]  frame_cnt;
   reg  [7:0]  reload_count;
   wire        int_tick   = running & internal_src & (int_cnt == INT_LAST);
   wire        host_tick  = running & !internal_src & vid_s2[1] & !vid_prev[1];
   wire        frame_tick = int_tick | host_tick;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         int_cnt <= 21'h000000;
      else if (!running || !internal_src || int_tick)
         int_cnt <= 21'h000000;
      else
         int_cnt <= int_cnt + 21'h000001;
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_cnt      <= 6'h00;
         reload_count   <= 8'h00;
         reload_request <= 1'b0;
      end else begin
         reload_request <= 1'b0;
         if (!rst_n_s || !auto_s) begin
            frame_cnt <= 6'h00;
         end else if (frame_tick) begin
            if (frame_cnt == RELOAD_LAST) begin
               frame_cnt      <= 6'h00;
               reload_request <= 1'b1;
               reload_count   <= reload_count + 8'h01;
            end else begin
               frame_cnt <= frame_cnt + 6'h01;
            end
         end
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chip_in_reset           <= 1'b1;
         standby_active          <= 1'b0;
         display_active          <= 1'b0;
         host_port_is_i2c        <= 1'b0;
         lvds_selected           <= 1'b0;
         timing_mode             <= `PDSC_MODE_SYNC;
         timing_mode_reserved    <= 1'b0;
         horizontal_scan_dir_eff <= 1'b1;
         vertical_scan_dir_eff   <= 1'b1;
         interlace_active        <= 1'b0;
         self_test_active        <= 1'b0;
         self_protect_active     <= 1'b0;
         internal_video_source   <= 1'b0;
         source_first_channel    <= SRC_FIRST;
         source_last_channel     <= `PDSC_SRC_CHANNELS;
         gate_first_line         <= GATE_FIRST;
         gate_last_line          <= `PDSC_GATE_LINES;
         reload_from_eeprom      <= 1'b0;
      end else begin
         chip_in_reset           <= (op_state == ST_RESET);
         standby_active          <= (op_state == ST_STANDBY);
         display_active          <= running;
         host_port_is_i2c        <= i2c_s;
         lvds_selected           <= eff_video;
         timing_mode             <= eff_mode;
         timing_mode_reserved    <= mode_resv;
         horizontal_scan_dir_eff <= eff_hdir;
         vertical_scan_dir_eff   <= eff_vdir;
         interlace_active        <= eff_intl;
         self_test_active        <= (op_state == ST_SELFTST);
         self_protect_active     <= (op_state == ST_PROTECT);
         internal_video_source   <= running & internal_src;
         source_first_channel    <= eff_hdir ? SRC_FIRST : `PDSC_SRC_CHANNELS;
         source_last_channel     <= eff_hdir ? `PDSC_SRC_CHANNELS : SRC_FIRST;
         gate_first_line         <= eff_vdir ? GATE_FIRST : `PDSC_GATE_LINES;
         gate_last_line          <= eff_vdir ? `PDSC_GATE_LINES : GATE_FIRST;
         reload_from_eeprom      <= eep_s;
      end
   end

   // ----------------------------------------
   // Status word
   // ----------------------------------------
   always @* begin
      status_word = {1'b0, frame_cnt, reload_count, missing, 1'b0,
                     eff_vdir, eff_hdir, eff_mode, eff_video, i2c_s,
                     eep_s, op_state, hw_sel_s, auto_s};
   end

endmodule // pdsc_top
`default_nettype wire
